// ===== hdl/udc_pkg.sv
package udc_pkg;
    localparam int UDC_WIDTH = 4;
    localparam logic [3:0] UDC_RESET_VALUE = 4'h0;
    localparam logic [3:0] UDC_MAX_COUNT = 4'h9;
    localparam logic [3:0] UDC_MIN_COUNT = 4'h0;
    localparam int UDC_SYNC_STAGES = 2;
    localparam int UDC_SYNC_STAGES_MIN = 2;

    typedef enum logic [1:0] {
        UDC_HOLD = 2'h0,
        UDC_UP = 2'h1,
        UDC_DOWN = 2'h3,
        UDC_LOAD = 2'h2
    } udc_mode_t;

    function automatic logic [3:0] udc_inc(input logic [3:0] v);
        if (v >= UDC_MAX_COUNT) begin
            return UDC_MIN_COUNT;
        end
        return v + 4'h1;
    endfunction

    function automatic logic [3:0] udc_dec(input logic [3:0] v);
        if (v == UDC_MIN_COUNT || v > UDC_MAX_COUNT) begin
            return UDC_MAX_COUNT;
        end
        return v - 4'h1;
    endfunction
endpackage

// ===== hdl/udc_sync.sv
`timescale 1ns/100ps
module udc_sync
    import udc_pkg::*;
#(
    parameter int STAGES = UDC_SYNC_STAGES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic async_in,
    output logic sync_out
);
    logic [STAGES-1:0] chain_q;

    if (STAGES < UDC_SYNC_STAGES_MIN) begin : g_stage_check
        $error("udc_sync needs at least two stages");
    end

    // idle level of the clock pins is high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            chain_q <= '1;
        end else begin
            chain_q <= {chain_q[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain_q[STAGES-1];
endmodule // udc_sync

// ===== hdl/udc_edge.sv
`timescale 1ns/100ps
module udc_edge
    import udc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic level_in,
    output logic rise,
    output logic level_q
);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            level_q <= 1'b1;
        end else begin
            level_q <= level_in;
        end
    end

    assign rise = level_in & ~level_q;
endmodule // udc_edge

// ===== hdl/udc_counter.sv
`timescale 1ns/100ps
module udc_counter
    import udc_pkg::*;
#(
    parameter int WIDTH = UDC_WIDTH
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic count_up_clock,
    input wire logic count_down_clock,
    input wire logic master_clear,
    input wire logic preset_load_n,
    input wire logic [WIDTH-1:0] preset_value,
    output logic [WIDTH-1:0] count_value,
    output logic carry_out_n,
    output logic borrow_out_n
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic up_s;
    logic down_s;
    logic up_rise;
    logic down_rise;
    logic up_prev;
    logic down_prev;
    logic carry_q;
    logic borrow_q;
    logic low_bit_free;
    logic [WIDTH-1:0] step_up;
    logic [WIDTH-1:0] step_down;
    udc_mode_t mode;
    logic ctrl_busy;
    logic up_held_q;
    logic down_held_q;

    if (WIDTH != UDC_WIDTH) begin : g_width_check
        $error("udc_counter supports only a four bit decade");
    end

    udc_sync u_sync_up (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .async_in(count_up_clock),
        .sync_out(up_s)
    );

    udc_sync u_sync_down (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .async_in(count_down_clock),
        .sync_out(down_s)
    );

    // edge history keeps tracking during clear and load
    udc_edge u_edge_up (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .level_in(up_s),
        .rise(up_rise),
        .level_q(up_prev)
    );

    udc_edge u_edge_down (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .level_in(down_s),
        .rise(down_rise),
        .level_q(down_prev)
    );

    // lowest bit only steps when the other clock rests high
    assign low_bit_free = (up_rise & down_s) | (down_rise & up_s);

    // wrap and recovery from illegal codes
    assign step_up = udc_inc(count_q);
    assign step_down = udc_dec(count_q);

    // clear wins over load; load over clocks
    assign mode = master_clear ? UDC_LOAD :
                  !preset_load_n ? UDC_LOAD :
                  (up_rise & down_s) ? UDC_UP :
                  (down_rise & up_s) ? UDC_DOWN :
                  UDC_HOLD;

    // one shared next-state for all four bits
    always_comb begin
        count_d = count_q;
        case (mode)
            UDC_UP: begin
                count_d = step_up;
            end
            UDC_DOWN: begin
                count_d = step_down;
            end
            UDC_LOAD: begin
                count_d = master_clear ? UDC_RESET_VALUE : preset_value;
            end
            UDC_HOLD: begin
                count_d = count_q;
            end
            default: begin
                count_d = count_q;
            end
        endcase
        if (!low_bit_free && mode != UDC_LOAD) begin
            count_d[0] = count_q[0];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= UDC_RESET_VALUE;
        end else begin
            count_q <= count_d;
        end
    end

    // carry from bits 0 and 3 with up clock low
    // carry releases once the up clock is high
    // borrow from zero count with down clock low
    // one-flop mirror of the synchronised clocks
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            carry_q <= 1'b1;
            borrow_q <= 1'b1;
        end else begin
            carry_q <= ~(count_d[0] & count_d[3] & ~up_s);
            borrow_q <= ~((count_d == UDC_MIN_COUNT) & ~down_s);
        end
    end

    assign carry_out_n = carry_q;
    assign borrow_out_n = borrow_q;
    assign count_value = count_q;

    // note a clock held low through clear or load
    // flags feed only the assertions below
    assign ctrl_busy = master_clear | ~preset_load_n;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            up_held_q <= 1'b0;
            down_held_q <= 1'b0;
        end else begin
            if (ctrl_busy && !up_s) begin
                up_held_q <= 1'b1;
            end else if (up_rise) begin
                up_held_q <= 1'b0;
            end
            if (ctrl_busy && !down_s) begin
                down_held_q <= 1'b1;
            end else if (down_rise) begin
                down_held_q <= 1'b0;
            end
        end
    end

    // assertions
    a_up_step: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (up_rise && down_s && !master_clear && preset_load_n
            && count_q < UDC_MAX_COUNT)
        |=> count_q == $past(count_q) + 4'h1)
        else $error("count did not step up");

    a_down_step: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (down_rise && up_s && !master_clear && preset_load_n
            && count_q > UDC_MIN_COUNT && count_q <= UDC_MAX_COUNT)
        |=> count_q == $past(count_q) - 4'h1)
        else $error("count did not step down");

    a_hold_idle: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!up_rise && !down_rise && !master_clear && preset_load_n)
        |=> $stable(count_q))
        else $error("count moved without a clock edge");

    a_low_bit_lock: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (up_rise && !down_s && !master_clear && preset_load_n)
        |=> count_q[0] == $past(count_q[0]))
        else $error("lowest bit toggled with other clock low");

    a_bit0_lock_down: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (down_rise && !up_s && !master_clear && preset_load_n)
        |=> count_q[0] == $past(count_q[0]))
        else $error("lowest bit toggled with up clock low");

    a_carry_flag: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (count_q == UDC_MAX_COUNT && !$past(up_s)) |-> !carry_out_n)
        else $error("carry not asserted at nine");

    a_carry_mirror: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (count_q == UDC_MAX_COUNT && $past(up_s)) |-> carry_out_n)
        else $error("carry low while up clock high");

    a_carry_rest: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!count_q[0] || !count_q[3]) |-> carry_out_n)
        else $error("carry low away from terminal count");

    a_carry_release: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!carry_out_n && up_s) |=> carry_out_n)
        else $error("carry stayed low after up clock rose");

    a_borrow_flag: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (count_d == UDC_MIN_COUNT && !down_s) |=> !borrow_out_n)
        else $error("borrow not asserted at zero");

    a_borrow_release: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!borrow_out_n && down_s) |=> borrow_out_n)
        else $error("borrow stayed low after down clock rose");

    a_borrow_rest: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (count_q != UDC_MIN_COUNT) |-> borrow_out_n)
        else $error("borrow low away from zero");

    a_preset_copy: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_clear && !preset_load_n) |=> count_q == $past(preset_value))
        else $error("preset value not loaded");

    a_clear_wins: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        master_clear [*2] |-> count_q == UDC_RESET_VALUE)
        else $error("clear did not hold count at zero");

    a_clear_over_load: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (master_clear && !preset_load_n) |=> count_q == UDC_RESET_VALUE)
        else $error("load overrode clear");

    a_wrap_up: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (mode == UDC_UP && count_q >= UDC_MAX_COUNT)
        |=> count_q == UDC_MIN_COUNT)
        else $error("up count did not wrap to zero");

    a_wrap_down: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (mode == UDC_DOWN && count_q == UDC_MIN_COUNT)
        |=> count_q == UDC_MAX_COUNT)
        else $error("down count did not wrap to nine");

    a_count_legal: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (mode == UDC_UP || mode == UDC_DOWN) |=> count_q <= UDC_MAX_COUNT)
        else $error("count left the decade range");

    a_edge_after_clear: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (master_clear ##1 (!master_clear && preset_load_n && up_rise
            && down_s))
        |=> count_q == 4'h1)
        else $error("edge after clear not counted");

    a_held_up_counts: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (up_held_q && up_rise && down_s && !master_clear && preset_load_n
            && count_q < UDC_MAX_COUNT)
        |=> count_q == $past(count_q) + 4'h1)
        else $error("up edge after clear or load not counted");

    a_held_down_counts: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (down_held_q && down_rise && up_s && !master_clear && preset_load_n
            && count_q > UDC_MIN_COUNT && count_q <= UDC_MAX_COUNT)
        |=> count_q == $past(count_q) - 4'h1)
        else $error("down edge after clear or load not counted");

    a_prev_tracks: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        ##1 (up_prev == $past(up_s) && down_prev == $past(down_s)))
        else $error("edge history lost");
endmodule // udc_counter

// ===== tb/udc_next_stage.sv
`timescale 1ns/100ps
module udc_next_stage (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic carry_in_n,
    input wire logic borrow_in_n,
    output logic [7:0] up_seen,
    output logic [7:0] dn_seen
);
    logic carry_q;
    logic borrow_q;
    // next stage counts the rising edges of carry and borrow
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            carry_q <= 1'b1;
            borrow_q <= 1'b1;
            up_seen <= 8'h00;
            dn_seen <= 8'h00;
        end else begin
            carry_q <= carry_in_n;
            borrow_q <= borrow_in_n;
            if (carry_in_n && !carry_q) begin
                up_seen <= up_seen + 8'h01;
            end
            if (borrow_in_n && !borrow_q) begin
                dn_seen <= dn_seen + 8'h01;
            end
        end
    end
endmodule // udc_next_stage

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
    import udc_pkg::*;
    typedef struct packed {
        logic [3:0] start;
        logic go_up;
        logic [3:0] exp_cnt;
        logic exp_tc;
    } udc_row_t;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic up = 1'b1;
    logic dn = 1'b1;
    logic clr = 1'b0;
    logic ld_n = 1'b1;
    logic [3:0] pv = 4'h0;
    logic [3:0] cv;
    logic co_n;
    logic bo_n;
    logic tc;
    logic [7:0] up_seen;
    logic [7:0] dn_seen;
    int n_fail = 0;
    int checked = 0;
    udc_row_t rows [6] = '{'{4'h3, 1'b1, 4'h4, 1'b1},
        '{4'h9, 1'b1, 4'h0, 1'b0}, '{4'h0, 1'b0, 4'h9, 1'b0},
        '{4'h5, 1'b0, 4'h4, 1'b1}, '{4'hF, 1'b1, 4'h0, 1'b0},
        '{4'hC, 1'b0, 4'h9, 1'b1}};

    always #50 sys_clk = ~sys_clk;

    udc_counter u_udc_counter (.sys_clk(sys_clk), .rstn(rstn),
        .count_up_clock(up), .count_down_clock(dn), .master_clear(clr),
        .preset_load_n(ld_n), .preset_value(pv), .count_value(cv),
        .carry_out_n(co_n), .borrow_out_n(bo_n));
    udc_next_stage u_udc_next_stage (.sys_clk(sys_clk), .rstn(rstn),
        .carry_in_n(co_n), .borrow_in_n(bo_n), .up_seen(up_seen),
        .dn_seen(dn_seen));

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic load(input logic [3:0] v);
        @(negedge sys_clk);
        pv = v;
        ld_n = 1'b0;
        wait_n(2);
        ld_n = 1'b1;
        wait_n(2);
    endtask

    // other clock is left at its current level while one clock pulses
    task automatic pulse(input logic go_up);
        @(negedge sys_clk);
        if (go_up) up = 1'b0;
        else dn = 1'b0;
        wait_n(4);
        tc = go_up ? co_n : bo_n;
        if (go_up) up = 1'b1;
        else dn = 1'b1;
        wait_n(5);
    endtask

    task automatic end_of_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end

    initial begin
        wait_n(4);
        rstn = 1'b1;
        wait_n(1);
        check("reset count", cv, 4'h0);
        check("idle carry", co_n, 1'b1);
        check("idle borrow", bo_n, 1'b1);
        $display("reset test done");
        foreach (rows[i]) begin
            load(rows[i].start);
            check("loaded count", cv, rows[i].start);
            pulse(rows[i].go_up);
            check("count", cv, rows[i].exp_cnt);
            check("terminal low", tc, rows[i].exp_tc);
            check("carry back", co_n, 1'b1);
            check("borrow back", bo_n, 1'b1);
            wait_n(10);
            check("both high hold", cv, rows[i].exp_cnt);
            $display("row %0d done", i);
        end
        check("next up", up_seen, 8'h02);
        check("next down", dn_seen, 8'h01);
        load(4'h4);
        dn = 1'b0;
        wait_n(3);
        pulse(1'b1);
        check("bit0 frozen", cv, 4'h4);
        dn = 1'b1;
        wait_n(5);
        check("held low counts", cv, 4'h3);
        up = 1'b0;
        wait_n(3);
        pulse(1'b0);
        check("bit0 frozen down", cv, 4'h3);
        load(4'h2);
        up = 1'b1;
        wait_n(5);
        check("count after load", cv, 4'h3);
        $display("clock low test done");
        up = 1'b0;
        clr = 1'b1;
        wait_n(3);
        up = 1'b1;
        wait_n(2);
        clr = 1'b0;
        wait_n(3);
        check("edge after clear", cv, 4'h1);
        load(4'h6);
        dn = 1'b0;
        clr = 1'b1;
        ld_n = 1'b0;
        wait_n(3);
        check("clear over load", cv, 4'h0);
        clr = 1'b0;
        wait_n(3);
        check("load after clear", cv, 4'h6);
        ld_n = 1'b1;
        dn = 1'b1;
        wait_n(5);
        check("down after load", cv, 4'h5);
        rstn = 1'b0;
        wait_n(1);
        check("second reset", cv, 4'h0);
        rstn = 1'b1;
        wait_n(2);
        check("carry after reset", co_n, 1'b1);
        check("borrow after reset", bo_n, 1'b1);
        $display("clear and reset test done");
        end_of_test();
    end
endmodule // tb
